// file: bench/rhc_heater_model.sv
`default_nettype none
// Heating element and the two temperature sensors
module rhc_heater_model (
   input  wire logic              clock_in,
   input  wire logic              drive_in,
   input  wire logic              broken_in,
   input  wire logic signed [7:0] rim_set_in,
   input  wire logic signed [7:0] amb_set_in,
   output logic                   sense_out,
   output logic signed [7:0]      rim_temp_out,
   output logic signed [7:0]      amb_temp_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Current builds up one clock after drive; an open element never conducts
   always_ff @(posedge clock_in) begin
      sense_out    <= drive_in & ~broken_in;
      rim_temp_out <= rim_set_in;
      amb_temp_out <= amb_set_in;
   end
endmodule
`default_nettype wire

// file: bench/rhc_top_tb.sv
`default_nettype none
`include "rhc_params.svh"
module rhc_top_tb;
   import rhc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CPS = 10;
   logic              clock_in = 1'b0;
   logic              nrst_in = 1'b0;
   logic [3:0]        addr_in = 4'h0;
   logic [15:0]       wdata_in = 16'h0000;
   logic              wr_in = 1'b0;
   logic              rd_in = 1'b0;
   logic [15:0]       rdata_out;
   logic signed [7:0] rim_temp, amb_temp, rim_set = 8'sh00, amb_set = 8'sh00;
   logic              sense, broken = 1'b0, precip_in = 1'b0, supply_ok_in = 1'b1;
   logic              heater_out, irq_out;
   logic [7:0]        status8_out;
   logic [15:0]       d;
   int                error_cnt = 0, n_checks = 0, cyc = 0, n, i;
   int                rim_t[4] = '{0, 0, 10, -30};
   int                amb_t[4] = '{0, -8, 10, -30};
   int                on_t[4] = '{25, 33, 5, 120};

   always #10 clock_in = ~clock_in;

   rhc_top #(.CYC_PER_SEC(CPS)) rhc_top_inst (
      .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rim_temp_in(rim_temp),
      .amb_temp_in(amb_temp), .heater_sense_in(sense), .precip_in(precip_in),
      .supply_ok_in(supply_ok_in), .heater_out(heater_out), .status8_out(status8_out),
      .irq_out(irq_out));

   rhc_heater_model rhc_heater_model_inst (
      .clock_in(clock_in), .drive_in(heater_out), .broken_in(broken),
      .rim_set_in(rim_set), .amb_set_in(amb_set), .sense_out(sense),
      .rim_temp_out(rim_temp), .amb_temp_out(amb_temp));

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Cut a hang short well past the expected run length
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 90000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // One-cycle write strobe; released on the edge that takes it
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clock_in);
      addr_in  <= a;
      wdata_in <= v;
      wr_in    <= 1'b1;
      @(posedge clock_in);
      wr_in    <= 1'b0;
   endtask

   // Read data appears in the cycle after the strobe and holds until the next read
   task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clock_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clock_in);
      rd_in   <= 1'b0;
      #1 v = rdata_out;
   endtask

   task automatic env(input int r, input int a);
      @(posedge clock_in);
      rim_set <= 8'(r);
      amb_set <= 8'(a);
   endtask

   // Bounded wait for the heater drive to reach a level
   task automatic wait_for(input logic lvl);
      int k;
      k = 0;
      while (heater_out !== lvl && k < 3000) begin
         @(negedge clock_in);
         k++;
      end
   endtask

   // Length of the next on-period in clocks
   task automatic measure_on(output int len);
      wait_for(1'b1);
      len = 0;
      while (heater_out === 1'b1 && len < 3000) begin
         @(negedge clock_in);
         len++;
      end
   endtask

   // Heater must stay off for the whole span, test pulses included
   task automatic quiet(input int span, input string msg);
      int hi;
      hi = 0;
      repeat (span) begin
         @(negedge clock_in);
         if (heater_out !== 1'b0) hi++;
      end
      chk(16'(hi), 16'h0000, msg);
   endtask

   initial begin
      repeat (3) @(posedge clock_in);
      nrst_in <= 1'b1;
      // Reset values, refused mode, unmapped address
      bus_rd(`RHC_A_MODE, d);
      chk(d, 16'h0001, "mode reset");
      bus_rd(`RHC_A_SETPOINT, d);
      chk(d, 16'h0004, "setpoint reset");
      bus_wr(`RHC_A_MODE, 16'h0005);
      bus_rd(`RHC_A_MODE, d);
      chk(d, 16'h0001, "mode 5 refused");
      bus_rd(4'hc, d);
      chk(d, 16'h0000, "unmapped read");
      bus_wr(`RHC_A_LIMIT, 16'h00ce);
      bus_rd(`RHC_A_LIMIT, d);
      chk(d, 16'h00d8, "limit clamp");
      bus_wr(`RHC_A_LIMIT, 16'h0000);
      chk({8'h00, status8_out}, 16'h0000, "status byte on");
      $display("Test reset done");
      // On-period from rim, ambient and setpoint, clamped to 5..120 s
      wait_for(1'b0);
      for (i = 0; i < 4; i++) begin
         env(rim_t[i], amb_t[i]);
         measure_on(n);
         chk(16'(n), 16'(on_t[i] * CPS), "on-period");
      end
      env(0, 0);
      $display("Test on-period done");
      // Safety cut while heating, with interrupt raised and cleared
      bus_wr(`RHC_A_IRQ_MASK, 16'h000f);
      wait_for(1'b1);
      repeat (40) @(negedge clock_in);
      env(51, 0);
      repeat (4) @(negedge clock_in);
      chk({15'h0, heater_out}, 16'h0000, "safety cut");
      chk({15'h0, irq_out}, 16'h0001, "irq raised");
      bus_rd(`RHC_A_IRQ_STAT, d);
      chk(d, 16'h0002, "trip event");
      chk({15'h0, irq_out}, 16'h0000, "irq cleared");
      env(0, 0);
      $display("Test safety done");
      // Three dead phases flag the heater, a good phase clears it
      wait_for(1'b0);
      broken <= 1'b1;
      repeat (3) begin
         wait_for(1'b1);
         wait_for(1'b0);
      end
      repeat (5) @(negedge clock_in);
      bus_rd(`RHC_A_STATUS, d);
      chk({15'h0, d[1]}, 16'h0001, "check failed");
      broken <= 1'b0;
      wait_for(1'b1);
      wait_for(1'b0);
      repeat (5) @(negedge clock_in);
      bus_rd(`RHC_A_STATUS, d);
      chk({15'h0, d[1]}, 16'h0000, "check recovered");
      bus_rd(`RHC_A_IRQ_STAT, d);
      chk({15'h0, d[0]}, 16'h0001, "check event");
      $display("Test self-test done");
      // Switched off, then mode zero
      bus_wr(`RHC_A_CTRL, 16'h0000);
      repeat (3) @(negedge clock_in);
      chk({8'h00, status8_out}, 16'h0040, "off flag");
      quiet(2500, "heater off");
      bus_wr(`RHC_A_MODE, 16'h0000);
      bus_wr(`RHC_A_CTRL, 16'h0001);
      repeat (3) @(negedge clock_in);
      chk({8'h00, status8_out}, 16'h0000, "off flag gone");
      quiet(2500, "mode zero");
      $display("Test off done");
      // Mode two gated by ambient against limit 0
      env(0, -5);
      bus_wr(`RHC_A_MODE, 16'h0002);
      quiet(2500, "mode two cold");
      env(0, 0);
      wait_for(1'b1);
      chk({15'h0, heater_out}, 16'h0001, "mode two warm");
      $display("Test mode two done");
      // Mode four after-run of one minute, masked then unmasked event
      bus_wr(`RHC_A_AFTERRUN, 16'h0001);
      bus_wr(`RHC_A_MODE, 16'h0004);
      bus_wr(`RHC_A_IRQ_MASK, 16'h0000);
      wait_for(1'b0);
      quiet(2500, "mode four dry");
      @(posedge clock_in);
      precip_in <= 1'b1;
      repeat (3) @(negedge clock_in);
      chk({15'h0, irq_out}, 16'h0000, "irq masked");
      bus_wr(`RHC_A_IRQ_MASK, 16'h0008);
      #1 chk({15'h0, irq_out}, 16'h0001, "irq unmasked");
      wait_for(1'b1);
      chk({15'h0, heater_out}, 16'h0001, "after-run heat");
      wait_for(1'b0);
      quiet(2500, "after-run over");
      bus_rd(`RHC_A_IRQ_STAT, d);
      chk(d, 16'h0008, "rain event");
      chk({15'h0, irq_out}, 16'h0000, "irq cleared");
      $display("Test mode four done");
      // Mode three daily window
      bus_wr(`RHC_A_TIME, 16'd100);
      bus_wr(`RHC_A_START, 16'd500);
      bus_wr(`RHC_A_ONTIME, 16'd60);
      bus_wr(`RHC_A_MODE, 16'h0003);
      quiet(2500, "outside window");
      bus_wr(`RHC_A_START, 16'd90);
      wait_for(1'b1);
      chk({15'h0, heater_out}, 16'h0001, "inside window");
      $display("Test mode three done");
      // Ten minutes without supply loses the time
      @(posedge clock_in);
      supply_ok_in <= 1'b0;
      repeat (600 * CPS + 40) @(negedge clock_in);
      bus_rd(`RHC_A_STATUS, d);
      chk({15'h0, d[3]}, 16'h0000, "time lost");
      bus_rd(`RHC_A_IRQ_STAT, d);
      chk({15'h0, d[2]}, 16'h0001, "time lost event");
      wait_for(1'b0);
      quiet(2500, "no window without time");
      $display("Test supply loss done");
      // One-hour interval outside the window gives one five-second test pulse
      bus_wr(`RHC_A_INTERVAL, 16'h0001);
      quiet(3600 * CPS - 100, "before interval");
      measure_on(n);
      chk(16'(n), 16'(5 * CPS), "test pulse");
      $display("Test interval done");
      test_done();
   end
endmodule
`default_nettype wire

// file: common/rhc_params.svh
`ifndef RHC_PARAMS_SVH
`define RHC_PARAMS_SVH

// Clock and time base
`define RHC_CLK_PERIOD_NS  1000000000
`define RHC_CLK_HZ_DIV     20
`define RHC_SEC_PER_MIN    16'd60
`define RHC_SEC_PER_HOUR   20'd3600
`define RHC_MIN_PER_DAY    16'd1440

// Regulation timing, in seconds
`define RHC_ON_MIN_S       11'sd5
`define RHC_ON_MAX_S       11'sd120
`define RHC_PERIOD_S       7'd120
`define RHC_SETTLE_S       7'd1

// Temperatures in whole degrees Celsius, and the on-period gains per degree
`define RHC_SETPOINT_RST   8'sd4
`define RHC_SAFETY_C       8'sd50
`define RHC_LIMIT_LO       11'sh7d8
`define RHC_LIMIT_HI       11'sd9
`define RHC_LIMIT_RST      8'sd0
`define RHC_GAIN_RIM       11'sd4
`define RHC_GAIN_AMB       11'sd1

// Adjustable windows and intervals, with the fixed supply-loss time and check failure limit
`define RHC_IVL_LO_H       16'd1
`define RHC_IVL_HI_H       16'd168
`define RHC_IVL_RST_H      8'd24
`define RHC_WIN_LO_MIN     16'd1
`define RHC_WIN_HI_MIN     16'd1440
`define RHC_WIN_RST_MIN    11'd60
`define RHC_START_HI_MIN   16'd1439
`define RHC_PWRFAIL_MIN    10
`define RHC_FAIL_LIMIT     2'd3

// Modes and status byte
`define RHC_MODE_MAX       3'd4
`define RHC_MODE_RST       3'd1
`define RHC_OFF_FLAG       8'h40

// Register word offsets
`define RHC_A_CTRL         4'h0
`define RHC_A_MODE         4'h1
`define RHC_A_SETPOINT     4'h2
`define RHC_A_LIMIT        4'h3
`define RHC_A_INTERVAL     4'h4
`define RHC_A_START        4'h5
`define RHC_A_ONTIME       4'h6
`define RHC_A_AFTERRUN     4'h7
`define RHC_A_TIME         4'h8
`define RHC_A_STATUS       4'h9
`define RHC_A_IRQ_STAT     4'ha
`define RHC_A_IRQ_MASK     4'hb

`endif

// file: common/rhc_pkg.sv
`default_nettype none
package rhc_pkg;
   // Regulation sequencer states
   typedef enum logic [1:0] {
      RHC_IDLE,
      RHC_HEAT,
      RHC_TEST,
      RHC_PAUSE
   } rhc_state_e;

   // Live status word
   typedef struct packed {
      logic regulating;
      logic time_valid;
      logic safety_trip;
      logic check_failed;
      logic heating;
   } rhc_status_s;

   // Sticky interrupt events
   typedef struct packed {
      logic precip_start;
      logic time_lost;
      logic safety_trip;
      logic check_failed;
   } rhc_events_s;
endpackage
`default_nettype wire

// file: rtl/rhc_top.sv
`default_nettype none
`include "rhc_params.svh"

// How it works
// - The rim is heated toward a setpoint that resets to plus four degrees.
// - The on-period comes from ambient, rim and setpoint temperatures together.
// - Each on-period lasts between five and 120 seconds.
// - While regulation runs, every on-period checks the heater current sense.
// - Three failed checks in a row set a check-failed status bit; a good check clears it.
// - Rim above 50 degrees while heating cuts the element at once.
// - A control bit switches the heater off and in the same cycle adds 64 to status byte eight.
// - Mode zero neither heats nor tests.
// - Mode one, the reset mode, regulates all the time.
// - Mode two regulates only while ambient is at or above a limit of -40 to +9.
// - Mode two below the limit runs a test pulse every one hour to seven days.
// - Mode three regulates from a start minute for one to 1440 minutes.
// - Mode three outside its window runs the periodic test pulse.
// - Supply loss over ten minutes invalidates the time and stops mode three.
// - Mode four regulates for an after-run of one to 1440 minutes from rain onset.
// - Mode four outside the after-run runs the periodic test pulse.
module rhc_top
   import rhc_pkg::*;
#(
   parameter int CYC_PER_SEC = `RHC_CLK_PERIOD_NS / `RHC_CLK_HZ_DIV
) (
   input  wire logic              clock_in,
   input  wire logic              nrst_in,
   input  wire logic [3:0]        addr_in,
   input  wire logic [15:0]       wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic      [15:0]       rdata_out,
   input  wire logic signed [7:0] rim_temp_in,
   input  wire logic signed [7:0] amb_temp_in,
   input  wire logic              heater_sense_in,
   input  wire logic              precip_in,
   input  wire logic              supply_ok_in,
   output logic                   heater_out,
   output logic      [7:0]        status8_out,
   output logic                   irq_out
);
   localparam int PF_SEC = `RHC_PWRFAIL_MIN * `RHC_SEC_PER_MIN;

   // Saturating clamp, signed temperatures and seconds
   function automatic logic signed [10:0] clamp_s(input logic signed [10:0] v,
                                                  input logic signed [10:0] lo,
                                                  input logic signed [10:0] hi);
      clamp_s = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // Saturating clamp, unsigned minutes and hours
   function automatic logic [15:0] clamp_u(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
      clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   logic [25:0]        sec_cnt;
   logic               heater_en;
   logic [2:0]         mode;
   logic [2:0]         act_mode;
   logic signed [7:0]  setpoint;
   logic signed [7:0]  t_limit;
   logic [7:0]         ivl_h;
   logic [10:0]        start_min;
   logic [10:0]        on_min;
   logic [10:0]        after_min;
   logic [10:0]        tod_min;
   logic [5:0]         tod_sec;
   logic               time_valid;
   logic [9:0]         pf_cnt;
   logic [19:0]        ivl_cnt;
   logic [16:0]        after_cnt;
   logic               precip_q;
   rhc_state_e         state;
   logic [6:0]         on_sec;
   logic [6:0]         per_cnt;
   logic               bad;
   logic [1:0]         fail_cnt;
   logic               fail;
   logic               trip;
   rhc_events_s        irq_st;
   rhc_events_s        irq_mask;
   rhc_status_s        status;

   // Time base and bus decode
   wire sec_tick  = (sec_cnt == 26'(CYC_PER_SEC - 1));
   wire wr_ctrl   = wr_in && (addr_in == `RHC_A_CTRL);
   wire wr_mode   = wr_in && (addr_in == `RHC_A_MODE);
   wire wr_sp     = wr_in && (addr_in == `RHC_A_SETPOINT);
   wire wr_lim    = wr_in && (addr_in == `RHC_A_LIMIT);
   wire wr_ivl    = wr_in && (addr_in == `RHC_A_INTERVAL);
   wire wr_start  = wr_in && (addr_in == `RHC_A_START);
   wire wr_ontime = wr_in && (addr_in == `RHC_A_ONTIME);
   wire wr_after  = wr_in && (addr_in == `RHC_A_AFTERRUN);
   wire wr_time   = wr_in && (addr_in == `RHC_A_TIME);
   wire wr_mask   = wr_in && (addr_in == `RHC_A_IRQ_MASK);
   wire rd_irq    = rd_in && (addr_in == `RHC_A_IRQ_STAT);

   // Temperature terms for the on-period, widened to 11 signed bits
   wire signed [10:0] sp_x   = 11'(setpoint);
   wire signed [10:0] rim_x  = 11'(rim_temp_in);
   wire signed [10:0] amb_x  = 11'(amb_temp_in);
   wire signed [10:0] demand = `RHC_ON_MIN_S + `RHC_GAIN_RIM * (sp_x - rim_x)
                               + `RHC_GAIN_AMB * (sp_x - amb_x);
   wire signed [10:0] on_clamped = clamp_s(demand, `RHC_ON_MIN_S, `RHC_ON_MAX_S);
   wire [6:0]         on_calc    = on_clamped[6:0];
   wire signed [10:0] lim_wr     = clamp_s(11'($signed(wdata_in[7:0])),
                                           `RHC_LIMIT_LO, `RHC_LIMIT_HI);

   // Minutes elapsed since the daily start, wrapped at midnight
   wire [10:0] win_diff = (tod_min >= start_min) ? (tod_min - start_min)
                          : 11'(`RHC_MIN_PER_DAY + 16'(tod_min) - 16'(start_min));
   wire        in_win   = win_diff < on_min;
   wire        hot      = rim_temp_in > `RHC_SAFETY_C;

   // Per-mode gating, sampled only at a decision
   logic want_reg;
   always_comb begin
      unique case (mode)
         3'd0:    want_reg = 1'b0;                     // mode zero off
         3'd1:    want_reg = 1'b1;                     // always regulating
         3'd2:    want_reg = amb_x >= 11'(t_limit);    // ambient limit
         3'd3:    want_reg = time_valid && in_win;     // daily window
         3'd4:    want_reg = after_cnt != 17'h0;       // after-run active
         default: want_reg = 1'b0;
      endcase
   end

   wire regulate  = heater_en && want_reg;
   wire test_due  = heater_en && (mode != 3'd0) && !want_reg && (ivl_cnt == 20'h0);
   wire driving   = (state == RHC_HEAT) || (state == RHC_TEST);
   wire next_heat = driving && heater_en && (act_mode != 3'd0) && !hot;
   wire phase_end = driving && sec_tick && ((per_cnt + 7'd1) >= on_sec);
   wire precip_up = precip_in && !precip_q;
   wire pf_hit    = sec_tick && !supply_ok_in && (pf_cnt == 10'(PF_SEC - 1));
   // A fresh interval write reloads with the new hours, not the old ones
   wire [7:0]  ivl_wr   = 8'(clamp_u(wdata_in, `RHC_IVL_LO_H, `RHC_IVL_HI_H));
   wire [7:0]  ivl_src  = !nrst_in ? `RHC_IVL_RST_H : (wr_ivl ? ivl_wr : ivl_h);
   wire [19:0] ivl_load = 20'(ivl_src * `RHC_SEC_PER_HOUR);

   rhc_events_s ev;
   assign ev.check_failed = phase_end && bad && (fail_cnt == `RHC_FAIL_LIMIT - 2'd1);
   assign ev.safety_trip  = driving && hot && !trip;
   assign ev.time_lost    = pf_hit && time_valid;
   assign ev.precip_start = precip_up;

   // Seconds prescaler
   always_ff @(posedge clock_in) begin
      if (!nrst_in || sec_tick) sec_cnt <= 26'h0;
      else                      sec_cnt <= sec_cnt + 26'h1;
   end

   // Software-written settings; out-of-range values are clamped, bad modes dropped
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         heater_en <= 1'b1;
         mode      <= `RHC_MODE_RST;
         setpoint  <= `RHC_SETPOINT_RST;
         t_limit   <= `RHC_LIMIT_RST;
         ivl_h     <= `RHC_IVL_RST_H;
         start_min <= 11'h0;
         on_min    <= `RHC_WIN_RST_MIN;
         after_min <= `RHC_WIN_RST_MIN;
         irq_mask  <= '0;
      end else begin
         if (wr_ctrl) heater_en <= wdata_in[0];
         if (wr_mode && (wdata_in[2:0] <= `RHC_MODE_MAX) && (wdata_in[15:3] == 13'h0))
            mode <= wdata_in[2:0];
         if (wr_sp)     setpoint  <= wdata_in[7:0];
         if (wr_lim)    t_limit   <= lim_wr[7:0];
         if (wr_ivl)    ivl_h     <= ivl_wr;
         if (wr_start)  start_min <= 11'(clamp_u(wdata_in, 16'h0, `RHC_START_HI_MIN));
         if (wr_ontime) on_min    <= 11'(clamp_u(wdata_in, `RHC_WIN_LO_MIN, `RHC_WIN_HI_MIN));
         if (wr_after)  after_min <= 11'(clamp_u(wdata_in, `RHC_WIN_LO_MIN, `RHC_WIN_HI_MIN));
         if (wr_mask)   irq_mask  <= wdata_in[3:0];
      end
   end

   // time of day and supply-loss watch
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         tod_min    <= 11'h0;
         tod_sec    <= 6'h0;
         time_valid <= 1'b0;
         pf_cnt     <= 10'h0;
      end else begin
         if (wr_time) begin
            tod_min    <= 11'(clamp_u(wdata_in, 16'h0, `RHC_START_HI_MIN));
            tod_sec    <= 6'h0;
            time_valid <= 1'b1;
         end else if (sec_tick) begin
            tod_sec <= (tod_sec == 6'(`RHC_SEC_PER_MIN - 16'd1)) ? 6'h0 : tod_sec + 6'h1;
            if (tod_sec == 6'(`RHC_SEC_PER_MIN - 16'd1))
               tod_min <= (tod_min == 11'(`RHC_START_HI_MIN)) ? 11'h0 : tod_min + 11'h1;
            if (pf_hit) time_valid <= 1'b0;
         end
         if (supply_ok_in)  pf_cnt <= 10'h0;
         else if (sec_tick && !pf_hit) pf_cnt <= pf_cnt + 10'h1;
      end
   end

   // after-run restarts on each rain onset
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         precip_q  <= 1'b0;
         after_cnt <= 17'h0;
      end else begin
         precip_q <= precip_in;
         if (precip_up)
            after_cnt <= 17'(after_min) * 17'(`RHC_SEC_PER_MIN);
         else if (sec_tick && after_cnt != 17'h0)
            after_cnt <= after_cnt - 17'h1;
      end
   end

   // test interval restarts whenever the heater is exercised
   always_ff @(posedge clock_in) begin
      if (!nrst_in || wr_ivl)                          ivl_cnt <= ivl_load;
      else if (sec_tick && state == RHC_IDLE && (regulate || test_due))
                                                       ivl_cnt <= ivl_load;
      else if (sec_tick && ivl_cnt != 20'h0)           ivl_cnt <= ivl_cnt - 20'h1;
   end

   // Regulation sequencer, stepped once a second
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         state    <= RHC_IDLE;
         act_mode <= `RHC_MODE_RST;
         on_sec   <= 7'(`RHC_ON_MIN_S);
         per_cnt  <= 7'h0;
      end else if (sec_tick) begin
         unique case (state)
            RHC_IDLE: begin
               act_mode <= mode;
               per_cnt  <= 7'h0;
               if (regulate) begin
                  state  <= RHC_HEAT;
                  on_sec <= on_calc;
               end else if (test_due) begin
                  state  <= RHC_TEST;
                  on_sec <= 7'(`RHC_ON_MIN_S);
               end
            end
            RHC_HEAT: begin
               per_cnt <= per_cnt + 7'h1;
               if (phase_end) state <= RHC_PAUSE;
            end
            RHC_TEST: begin
               per_cnt <= per_cnt + 7'h1;
               if (phase_end) state <= RHC_IDLE;
            end
            RHC_PAUSE: begin
               per_cnt <= per_cnt + 7'h1;
               if ((per_cnt + 7'd1) >= `RHC_PERIOD_S) state <= RHC_IDLE;
            end
         endcase
      end
   end

   // current check each driven second after settling
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         bad      <= 1'b0;
         fail_cnt <= 2'h0;
         fail     <= 1'b0;
      end else if (phase_end) begin
         bad <= 1'b0;
         if (bad) begin
            if (fail_cnt != `RHC_FAIL_LIMIT) fail_cnt <= fail_cnt + 2'h1;
            if (ev.check_failed)             fail     <= 1'b1;
         end else begin
            fail_cnt <= 2'h0;
            fail     <= 1'b0;
         end
      end else if (sec_tick && heater_out && per_cnt >= `RHC_SETTLE_S && !heater_sense_in) begin
         bad <= 1'b1;
      end
   end

   // Output drive, trip flag and status byte
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         heater_out  <= 1'b0;
         trip        <= 1'b0;
         status8_out <= 8'h00;
      end else begin
         heater_out  <= next_heat;
         trip        <= driving && hot;
         status8_out <= heater_en ? 8'h00 : `RHC_OFF_FLAG;
      end
   end

   // Sticky events; a read clears, but a same-cycle event survives
   always_ff @(posedge clock_in) begin
      if (!nrst_in) irq_st <= '0;
      else          irq_st <= (rd_irq ? rhc_events_s'(4'h0) : irq_st) | ev;
   end

   assign status.regulating   = state == RHC_HEAT;
   assign status.time_valid   = time_valid;
   assign status.safety_trip  = trip;
   assign status.check_failed = fail;
   assign status.heating      = heater_out;
   assign irq_out             = |(irq_st & irq_mask);

   // Read mux, unmapped offsets read zero
   logic [15:0] rd_mux;
   always_comb begin
      unique case (addr_in)
         `RHC_A_CTRL:     rd_mux = {15'h0, heater_en};
         `RHC_A_MODE:     rd_mux = {13'h0, mode};
         `RHC_A_SETPOINT: rd_mux = {8'h0, setpoint};
         `RHC_A_LIMIT:    rd_mux = {8'h0, t_limit};
         `RHC_A_INTERVAL: rd_mux = {8'h0, ivl_h};
         `RHC_A_START:    rd_mux = {5'h0, start_min};
         `RHC_A_ONTIME:   rd_mux = {5'h0, on_min};
         `RHC_A_AFTERRUN: rd_mux = {5'h0, after_min};
         `RHC_A_TIME:     rd_mux = {5'h0, tod_min};
         `RHC_A_STATUS:   rd_mux = {11'h0, status};
         `RHC_A_IRQ_STAT: rd_mux = {12'h0, irq_st};
         `RHC_A_IRQ_MASK: rd_mux = {12'h0, irq_mask};
         default:         rd_mux = 16'h0;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in)   rdata_out <= 16'h0;
      else if (rd_in) rdata_out <= rd_mux;
   end

   a_safety_cut: assert property (@(posedge clock_in) disable iff (!nrst_in)
      hot |=> !heater_out) else $error("heater on above rim limit");
   a_mode0_off: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (act_mode == 3'd0) ##1 (act_mode == 3'd0) |-> !heater_out)
      else $error("heater driven in mode zero");
   a_on_bounds: assert property (@(posedge clock_in) disable iff (!nrst_in)
      driving |-> (on_sec >= 7'd5) && (on_sec <= 7'd120)) else $error("on-period out of range");
   a_off_flag: assert property (@(posedge clock_in) disable iff (!nrst_in)
      !heater_en ##1 !heater_en |-> status8_out == 8'h40 && !heater_out)
      else $error("off flag or drive wrong");
   a_mode_range: assert property (@(posedge clock_in) disable iff (!nrst_in)
      mode <= 3'd4) else $error("mode illegal");
   a_mode_reset: assert property (@(posedge clock_in) disable iff (!nrst_in)
      $rose(nrst_in) |-> mode == 3'd1) else $error("mode not one after reset");
   a_fail_set: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ev.check_failed |=> fail && irq_st.check_failed) else $error("fault not flagged");
   a_time_lost: assert property (@(posedge clock_in) disable iff (!nrst_in)
      pf_hit && !wr_time |=> !time_valid && !(state == RHC_IDLE && mode == 3'd3 && regulate))
      else $error("time kept after long supply loss");
   a_event_wins: assert property (@(posedge clock_in) disable iff (!nrst_in)
      rd_irq |=> irq_st == $past(ev)) else $error("event lost on clear");
   a_period_cap: assert property (@(posedge clock_in) disable iff (!nrst_in)
      driving |-> per_cnt < 7'd120) else $error("drive phase too long");
   a_limit_range: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (t_limit >= -8'sd40) && (t_limit <= 8'sd9)) else $error("limit out of range");
endmodule
`default_nettype wire
